//--- fvs_setup_regs.v
// How it works
// - control bits 0-3 enable gated tach mode for tach inputs 1-4.
// - bit 4 gives lookup fan controls 1 and 2 half-degree resolution.
// - bit 5 gives lookup fan controls 3 and 4 half-degree resolution.
// - bits 7:6 pick the vid decode mode for vid value and window.
// - mode 00 decodes six pins, 12.5 mV steps, 0.8375 V to 1.6 V.
// - mode 01 decodes seven pins, 6.25 mV steps, 0.83125 V to 1.6 V.
// - mode 10 uses pins 6..0, pin 7 taken as zero, 6.25 mV steps.
// - mode 11 uses pins 7..1, pin 0 zero, 12.5 mV from 0.0375 V.
// - threshold bit 0 lowers thresholds on all cpu vid inputs.
// - bits 2 and 3 lower gpi 8 and 9 thresholds, six-bit mode only.
// - bits 4-7 lower thresholds on gpio inputs 4 through 7.
// - both registers read and write, reset to 00; bit 1 unused.
`timescale 1ns/10ps
`include "fvs_setup_regs.vh"
`default_nettype none

module fvs_setup_regs #(
    parameter [6:0] SLAVE_ADDR = 7'h2c // arbitrary value
) (
    // clock and reset
    input wire mclk_in,
    input wire nrst_in,
    // serial port
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_out,
    // vid pins
    input wire [7:0] vid_pins_in,
    // tach and lookup control
    output wire gated_tach_enable_a_out,
    output wire gated_tach_enable_b_out,
    output wire gated_tach_enable_c_out,
    output wire gated_tach_enable_d_out,
    output wire lut_pair_a_half_degree_out,
    output wire lut_pair_b_half_degree_out,
    // vid decode
    output wire [1:0] vid_decode_select_out,
    output wire [8:0] vid_level_out,
    // pad thresholds
    output wire cpu_vid_low_threshold_out,
    output wire gpi_eight_low_threshold_out,
    output wire gpi_nine_low_threshold_out,
    output wire gpio_four_low_threshold_out,
    output wire gpio_five_low_threshold_out,
    output wire gpio_six_low_threshold_out,
    output wire gpio_seven_low_threshold_out
);

// serial engine states
localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_ADDR = 4'h1;
localparam [3:0] ST_ADDR_ACK = 4'h2;
localparam [3:0] ST_CMD = 4'h3;
localparam [3:0] ST_CMD_ACK = 4'h4;
localparam [3:0] ST_WDATA = 4'h5;
localparam [3:0] ST_WDATA_ACK = 4'h6;
localparam [3:0] ST_RDATA = 4'h7;
localparam [3:0] ST_RDATA_ACK = 4'h8;

reg [7:0] func_ctrl;
reg [7:0] thresh_sel;
reg gpi_eight_gated;
reg gpi_nine_gated;

reg [3:0] state;
reg [2:0] bit_cnt;
reg byte_done;
reg [7:0] shreg;
reg [7:0] pointer;
reg read_dir;
reg sda_drive;
reg sda_level;

reg [7:0] read_data;
wire scl_rise;
wire scl_fall;
wire bus_start;
wire bus_stop;
wire wr_strobe;
wire six_bit_mode;

fvs_line_edges u_edges (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(bus_start),
    .stop_out(bus_stop)
);

// vid code follows the selected mode
fvs_vid_decode u_vid (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .mode_in(func_ctrl[`FVS_FC_VID_HI:`FVS_FC_VID_LO]),
    .vid_pins_in(vid_pins_in),
    .level_out(vid_level_out)
);

// read mux; unmapped offsets read as zero
always @* begin
    case (pointer)
        `FVS_ADDR_FUNC_CTRL: read_data = func_ctrl;
        `FVS_ADDR_THRESH_SEL: read_data = thresh_sel;
        default: read_data = 8'h00;
    endcase
end

// a data byte lands when its ack window opens
assign wr_strobe = (state == ST_WDATA) && byte_done && scl_fall;

// register storage, whole byte written at once
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        func_ctrl <= `FVS_RST_FUNC_CTRL;
        thresh_sel <= `FVS_RST_THRESH_SEL;
    end else if (wr_strobe) begin
        if (pointer == `FVS_ADDR_FUNC_CTRL) begin
            func_ctrl <= shreg;
        end
        if (pointer == `FVS_ADDR_THRESH_SEL) begin
            // bit 1 is kept for readback only and drives nothing
            thresh_sel <= shreg;
        end
    end
end

assign six_bit_mode = (func_ctrl[`FVS_FC_VID_HI:`FVS_FC_VID_LO] ==
    `FVS_VID_SIX_BIT);

// gpi 8/9 lowering only counts in six-bit mode, pins are vid pins else
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        gpi_eight_gated <= 1'b0;
        gpi_nine_gated <= 1'b0;
    end else begin
        gpi_eight_gated <= thresh_sel[`FVS_TS_GPI_EIGHT] & six_bit_mode;
        gpi_nine_gated <= thresh_sel[`FVS_TS_GPI_NINE] & six_bit_mode;
    end
end

// bit shifter: sample on rising clock, count eight bits per byte
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
        shreg <= 8'h00;
    end else if (bus_start || bus_stop) begin
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
    end else if (scl_rise && (state == ST_ADDR || state == ST_CMD ||
        state == ST_WDATA)) begin
        shreg <= {shreg[6:0], sda_in};
        bit_cnt <= bit_cnt + 3'h1;
        byte_done <= (bit_cnt == 3'h7);
    end else if (scl_rise && state == ST_RDATA) begin
        bit_cnt <= bit_cnt + 3'h1;
        byte_done <= (bit_cnt == 3'h7);
    end else if (scl_fall && byte_done) begin
        byte_done <= 1'b0;
    end
end

// protocol engine: byte write, byte read and sequential bursts
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        state <= ST_IDLE;
        pointer <= 8'h00;
        read_dir <= 1'b0;
        sda_drive <= 1'b0;
        sda_level <= 1'b1;
    end else if (bus_stop) begin
        state <= ST_IDLE;
        sda_drive <= 1'b0;
        sda_level <= 1'b1;
    end else if (bus_start) begin
        // repeated start keeps the pointer for the read phase
        state <= ST_ADDR;
        sda_drive <= 1'b0;
        sda_level <= 1'b1;
    end else begin
        case (state)
            ST_IDLE: begin
                sda_drive <= 1'b0;
                sda_level <= 1'b1;
            end
            ST_ADDR: begin
                if (scl_fall && byte_done) begin
                    if (shreg[7:1] == SLAVE_ADDR) begin
                        read_dir <= shreg[0];
                        sda_drive <= 1'b1;
                        sda_level <= 1'b0;
                        state <= ST_ADDR_ACK;
                    end else begin
                        state <= ST_IDLE; // not ours, stay off the bus
                    end
                end
            end
            ST_ADDR_ACK: begin
                if (scl_fall) begin
                    if (read_dir) begin
                        sda_drive <= ~read_data[7];
                        sda_level <= read_data[7];
                        state <= ST_RDATA;
                    end else begin
                        sda_drive <= 1'b0;
                        sda_level <= 1'b1;
                        state <= ST_CMD;
                    end
                end
            end
            ST_CMD: begin
                if (scl_fall && byte_done) begin
                    pointer <= shreg;
                    sda_drive <= 1'b1;
                    sda_level <= 1'b0;
                    state <= ST_CMD_ACK;
                end
            end
            ST_CMD_ACK: begin
                if (scl_fall) begin
                    sda_drive <= 1'b0;
                    sda_level <= 1'b1;
                    state <= ST_WDATA;
                end
            end
            ST_WDATA: begin
                // every data byte is acked, even to an unmapped offset
                if (scl_fall && byte_done) begin
                    sda_drive <= 1'b1;
                    sda_level <= 1'b0;
                    state <= ST_WDATA_ACK;
                end
            end
            ST_WDATA_ACK: begin
                if (scl_fall) begin
                    pointer <= pointer + 8'h01;
                    sda_drive <= 1'b0;
                    sda_level <= 1'b1;
                    state <= ST_WDATA;
                end
            end
            ST_RDATA: begin
                if (scl_fall && byte_done) begin
                    sda_drive <= 1'b0; // free the line for master ack
                    sda_level <= 1'b1;
                    state <= ST_RDATA_ACK;
                end else if (scl_fall) begin
                    // open drain: only a zero bit pulls the line
                    sda_drive <= ~read_data[3'h7 - bit_cnt];
                    sda_level <= read_data[3'h7 - bit_cnt];
                end
            end
            ST_RDATA_ACK: begin
                if (scl_rise) begin
                    pointer <= pointer + 8'h01;
                    if (sda_in) begin
                        state <= ST_IDLE; // nack ends the burst
                    end
                end else if (scl_fall) begin
                    sda_drive <= ~read_data[7];
                    sda_level <= read_data[7];
                    state <= ST_RDATA;
                end
            end
            default: begin
                state <= ST_IDLE;
                sda_drive <= 1'b0;
                sda_level <= 1'b1;
            end
        endcase
    end
end

// pad drive; value flop is kept the inverse of the enable flop, so the
// pad sees no gate between register and pin
assign sda_out = sda_level;
assign sda_oe_out = sda_drive;

// control outputs come straight off the stored register
assign gated_tach_enable_a_out = func_ctrl[`FVS_FC_TACH_LO];
assign gated_tach_enable_b_out = func_ctrl[`FVS_FC_TACH_LO + 1];
assign gated_tach_enable_c_out = func_ctrl[`FVS_FC_TACH_LO + 2];
assign gated_tach_enable_d_out = func_ctrl[`FVS_FC_TACH_HI];
assign lut_pair_a_half_degree_out = func_ctrl[`FVS_FC_LUT_A];
assign lut_pair_b_half_degree_out = func_ctrl[`FVS_FC_LUT_B];
assign vid_decode_select_out =
    func_ctrl[`FVS_FC_VID_HI:`FVS_FC_VID_LO];

// threshold selects held as steady levels to the pads
assign cpu_vid_low_threshold_out = thresh_sel[`FVS_TS_CPU_VID];
assign gpi_eight_low_threshold_out = gpi_eight_gated;
assign gpi_nine_low_threshold_out = gpi_nine_gated;
assign gpio_four_low_threshold_out = thresh_sel[`FVS_TS_GPIO_LO];
assign gpio_five_low_threshold_out = thresh_sel[`FVS_TS_GPIO_LO + 1];
assign gpio_six_low_threshold_out = thresh_sel[`FVS_TS_GPIO_LO + 2];
assign gpio_seven_low_threshold_out = thresh_sel[`FVS_TS_GPIO_HI];

endmodule // fvs_setup_regs

`default_nettype wire

//--- fvs_setup_regs.vh
`ifndef FVS_SETUP_REGS_VH
`define FVS_SETUP_REGS_VH

// register offsets on the serial command byte
`define FVS_ADDR_FUNC_CTRL 8'hbd
`define FVS_ADDR_THRESH_SEL 8'hbe

// reset values
`define FVS_RST_FUNC_CTRL 8'h00
`define FVS_RST_THRESH_SEL 8'h00

// function control field positions
`define FVS_FC_TACH_LO 0
`define FVS_FC_TACH_HI 3
`define FVS_FC_LUT_A 4
`define FVS_FC_LUT_B 5
`define FVS_FC_VID_LO 6
`define FVS_FC_VID_HI 7

// threshold select field positions
`define FVS_TS_CPU_VID 0
`define FVS_TS_RESERVED 1
`define FVS_TS_GPI_EIGHT 2
`define FVS_TS_GPI_NINE 3
`define FVS_TS_GPIO_LO 4
`define FVS_TS_GPIO_HI 7

// vid decode modes
`define FVS_VID_SIX_BIT 2'h0
`define FVS_VID_EXTENDED 2'h1
`define FVS_VID_SEVEN_LOW 2'h2
`define FVS_VID_SEVEN_HIGH 2'h3

// vid level in 6.25 mV units: full scale 1.600 V and per-mode floors
`define FVS_VID_FULL 9'h100
`define FVS_VID_FLOOR_SIX 9'h086
`define FVS_VID_FLOOR_SEVEN 9'h085
`define FVS_VID_FLOOR_LOW 9'h006

`endif

//--- fvs_line_edges.v
`timescale 1ns/10ps
`default_nettype none

// clock and data line events of the serial port
module fvs_line_edges (
    // clock and reset
    input wire mclk_in,
    input wire nrst_in,
    // serial lines
    input wire scl_in,
    input wire sda_in,
    // one-cycle events
    output wire scl_rise_out,
    output wire scl_fall_out,
    output wire start_out,
    output wire stop_out
);

reg scl_prev;
reg sda_prev;

// previous line levels; reset to idle-high so no false edge after reset
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        scl_prev <= 1'b1;
        sda_prev <= 1'b1;
    end else begin
        scl_prev <= scl_in;
        sda_prev <= sda_in;
    end
end

// data moves while clock high mark start and stop
assign scl_rise_out = scl_in & ~scl_prev;
assign scl_fall_out = ~scl_in & scl_prev;
assign start_out = scl_in & scl_prev & sda_prev & ~sda_in;
assign stop_out = scl_in & scl_prev & ~sda_prev & sda_in;

endmodule // fvs_line_edges

`default_nettype wire

//--- fvs_vid_decode.v
`timescale 1ns/10ps
`include "fvs_setup_regs.vh"
`default_nettype none

// vid pin code to core voltage level, in 6.25 mV units
module fvs_vid_decode (
    // clock and reset
    input wire mclk_in,
    input wire nrst_in,
    // mode and pins
    input wire [1:0] mode_in,
    input wire [7:0] vid_pins_in,
    // decoded level
    output reg [8:0] level_out
);

reg [6:0] idx;
reg coarse;
reg [8:0] floor_lvl;
wire [8:0] drop;
wire [8:0] raw;

// pick the pins and step size per mode
always @* begin
    idx = 7'h00;
    coarse = 1'b0;
    floor_lvl = `FVS_VID_FLOOR_SEVEN;
    case (mode_in)
        `FVS_VID_SIX_BIT: begin
            idx = {1'b0, vid_pins_in[5:0]};
            coarse = 1'b1;
            floor_lvl = `FVS_VID_FLOOR_SIX;
        end
        `FVS_VID_EXTENDED: begin
            // extra pin acts as the half step
            idx = {vid_pins_in[5:0], vid_pins_in[6]};
        end
        `FVS_VID_SEVEN_LOW: begin
            idx = vid_pins_in[6:0];
        end
        `FVS_VID_SEVEN_HIGH: begin
            idx = vid_pins_in[7:1];
            coarse = 1'b1;
            floor_lvl = `FVS_VID_FLOOR_LOW;
        end
        default: begin
            idx = 7'h00;
        end
    endcase
end

assign drop = coarse ? {1'b0, idx, 1'b0} : {2'b00, idx};
assign raw = `FVS_VID_FULL - drop;

// clamp to the bottom of each mode's range
always @(posedge mclk_in) begin
    if (!nrst_in) begin
        level_out <= 9'h000;
    end else if (raw < floor_lvl) begin
        level_out <= floor_lvl;
    end else begin
        level_out <= raw;
    end
end

endmodule // fvs_vid_decode

`default_nettype wire

//--- fvs_setup_regs_monitor.sv
`timescale 1ns/10ps
`include "fvs_setup_regs.vh"
`default_nettype none
module fvs_setup_regs_monitor (
    // clock and reset
    input wire mclk_in,
    input wire nrst_in,
    // serial and vid inputs
    input wire scl_in,
    input wire sda_oe_out,
    input wire sda_out,
    input wire [7:0] vid_pins_in,
    // control outputs
    input wire gated_tach_enable_a_out,
    input wire gated_tach_enable_b_out,
    input wire gated_tach_enable_c_out,
    input wire gated_tach_enable_d_out,
    input wire lut_pair_a_half_degree_out,
    input wire lut_pair_b_half_degree_out,
    input wire [1:0] vid_decode_select_out,
    input wire [8:0] vid_level_out,
    // pad thresholds
    input wire cpu_vid_low_threshold_out,
    input wire gpi_eight_low_threshold_out,
    input wire gpi_nine_low_threshold_out,
    input wire gpio_four_low_threshold_out,
    input wire gpio_five_low_threshold_out,
    input wire gpio_six_low_threshold_out,
    input wire gpio_seven_low_threshold_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);

    // gathered views of the register-driven outputs
    wire [7:0] ctl = {vid_decode_select_out, lut_pair_b_half_degree_out,
        lut_pair_a_half_degree_out, gated_tach_enable_d_out,
        gated_tach_enable_c_out, gated_tach_enable_b_out,
        gated_tach_enable_a_out};
    wire [4:0] thr = {gpio_seven_low_threshold_out,
        gpio_six_low_threshold_out, gpio_five_low_threshold_out,
        gpio_four_low_threshold_out, cpu_vid_low_threshold_out};

    // expected level: linear from full scale, clamped at the mode floor
    function automatic [8:0] lvl(input [1:0] m, input [7:0] p);
        reg [8:0] dn;
        reg [8:0] fl;
        begin
            dn = (m == 2'h0) ? {2'h0, p[5:0], 1'b0} :
                (m == 2'h1) ? {2'h0, p[5:0], p[6]} :
                (m == 2'h2) ? {2'h0, p[6:0]} : {1'b0, p[7:1], 1'b0};
            fl = (m == 2'h0) ? `FVS_VID_FLOOR_SIX :
                (m == 2'h3) ? `FVS_VID_FLOOR_LOW : `FVS_VID_FLOOR_SEVEN;
            lvl = (`FVS_VID_FULL - dn < fl) ? fl : `FVS_VID_FULL - dn;
        end
    endfunction

    // no register update can land while scl sits high
    sequence scl_held;
        scl_in ##1 scl_in ##1 scl_in;
    endsequence

    // sampled reset in the antecedent skips the release edge itself
    property p_decode(m);
        nrst_in && vid_decode_select_out == m |=>
            vid_level_out == lvl(m, $past(vid_pins_in));
    endproperty

    a_six_bit_decode:
    assert property (p_decode(`FVS_VID_SIX_BIT)) else $error("six bit level");
    a_extended_decode:
    assert property (p_decode(`FVS_VID_EXTENDED)) else $error("ext level");
    a_seven_low_decode:
    assert property (p_decode(`FVS_VID_SEVEN_LOW)) else $error("mode2 level");
    a_seven_high_decode:
    assert property (p_decode(`FVS_VID_SEVEN_HIGH)) else $error("mode3 level");
    a_gpi_eight_gate:
    assert property (vid_decode_select_out != `FVS_VID_SIX_BIT
        |=> !gpi_eight_low_threshold_out) else $error("gpi8 not gated");
    a_gpi_nine_gate:
    assert property (vid_decode_select_out != `FVS_VID_SIX_BIT
        |=> !gpi_nine_low_threshold_out) else $error("gpi9 not gated");
    a_thresh_static:
    assert property (scl_held |-> $stable(thr)) else $error("thresh moved");
    a_ctrl_static:
    assert property (scl_held |-> $stable(ctl)) else $error("ctrl moved");
    a_reset_clear:
    assert property (disable iff (1'b0) !nrst_in |=> ctl == 8'h00
        && thr == 5'h00 && !sda_oe_out) else $error("reset not clear");
    a_pad_value:
    assert property (sda_out == !sda_oe_out) else $error("pad value wrong");
endmodule // fvs_setup_regs_monitor

bind fvs_setup_regs fvs_setup_regs_monitor fvs_setup_regs_monitor_inst (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .scl_in(scl_in),
    .sda_oe_out(sda_oe_out), .sda_out(sda_out),
    .vid_pins_in(vid_pins_in),
    .gated_tach_enable_a_out(gated_tach_enable_a_out),
    .gated_tach_enable_b_out(gated_tach_enable_b_out),
    .gated_tach_enable_c_out(gated_tach_enable_c_out),
    .gated_tach_enable_d_out(gated_tach_enable_d_out),
    .lut_pair_a_half_degree_out(lut_pair_a_half_degree_out),
    .lut_pair_b_half_degree_out(lut_pair_b_half_degree_out),
    .vid_decode_select_out(vid_decode_select_out),
    .vid_level_out(vid_level_out),
    .cpu_vid_low_threshold_out(cpu_vid_low_threshold_out),
    .gpi_eight_low_threshold_out(gpi_eight_low_threshold_out),
    .gpi_nine_low_threshold_out(gpi_nine_low_threshold_out),
    .gpio_four_low_threshold_out(gpio_four_low_threshold_out),
    .gpio_five_low_threshold_out(gpio_five_low_threshold_out),
    .gpio_six_low_threshold_out(gpio_six_low_threshold_out),
    .gpio_seven_low_threshold_out(gpio_seven_low_threshold_out)
);
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam [6:0] DEV = 7'h2c;
    // bench state and device outputs
    reg mclk_in = 1'b0;
    reg nrst_in = 1'b0;
    reg scl_in = 1'b1;
    reg sda_host = 1'b1;
    reg [7:0] vid_pins_in = 8'h00;
    wire sda_in;
    wire sda_out;
    wire sda_oe_out;
    wire [5:0] ctl;
    wire [1:0] vsel;
    wire [8:0] vid_level_out;
    wire [6:0] thr;
    integer seed = 32'h505c;
    integer n_fail = 0;
    integer samples_checked = 0;
    integer m;
    reg [31:0] v;
    reg [7:0] bd;
    reg [7:0] be;
    reg [7:0] d;
    reg [7:0] d2;
    reg [15:0] e;
    reg [15:0] g;
    reg [15:0] exp_q[$];
    reg [15:0] got_q[$];
    event res_ev;

    // open-drain line with pull-up: either side can pull low
    assign sda_in = sda_host & ~sda_oe_out;

    // 25 MHz clock
    always #20 mclk_in = ~mclk_in;

    fvs_setup_regs fvs_setup_regs_inst (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .vid_pins_in(vid_pins_in),
        .gated_tach_enable_a_out(ctl[0]), .gated_tach_enable_b_out(ctl[1]),
        .gated_tach_enable_c_out(ctl[2]), .gated_tach_enable_d_out(ctl[3]),
        .lut_pair_a_half_degree_out(ctl[4]),
        .lut_pair_b_half_degree_out(ctl[5]),
        .vid_decode_select_out(vsel), .vid_level_out(vid_level_out),
        .cpu_vid_low_threshold_out(thr[0]),
        .gpi_eight_low_threshold_out(thr[1]),
        .gpi_nine_low_threshold_out(thr[2]),
        .gpio_four_low_threshold_out(thr[3]),
        .gpio_five_low_threshold_out(thr[4]),
        .gpio_six_low_threshold_out(thr[5]),
        .gpio_seven_low_threshold_out(thr[6])
    );

    task tick(input integer n);
        repeat (n) @(posedge mclk_in);
    endtask

    // note the expectation beside the result; the watcher compares
    task chk(input [15:0] ex, input [15:0] gt);
        exp_q.push_back(ex);
        got_q.push_back(gt);
        -> res_ev;
    endtask

    // one bit slot; phases of four clocks keep well above the minimum
    task bit_io(input b, output r);
        sda_host <= b;
        tick(2);
        scl_in <= 1'b1;
        tick(3);
        #1 r = sda_in;
        tick(1);
        scl_in <= 1'b0;
        tick(2);
    endtask

    task bus_start;
        sda_host <= 1'b1;
        tick(2);
        scl_in <= 1'b1;
        tick(3);
        sda_host <= 1'b0;
        tick(3);
        scl_in <= 1'b0;
        tick(2);
    endtask

    task bus_stop;
        sda_host <= 1'b0;
        tick(2);
        scl_in <= 1'b1;
        tick(3);
        sda_host <= 1'b1;
        tick(4);
    endtask

    // msb first, ninth slot released so the device can ack
    task byte_io(input [7:0] b, output [7:0] r, output ack);
        integer i;
        reg x;
        for (i = 7; i >= 0; i = i - 1) begin
            bit_io(b[i], x);
            r[i] = x;
        end
        bit_io(1'b1, x);
        ack = ~x;
    endtask

    task wr(input [6:0] a, input [7:0] o, input [7:0] dv);
        reg [7:0] r;
        reg k;
        bus_start;
        byte_io({a, 1'b0}, r, k);
        chk({15'h0000, a == DEV}, {15'h0000, k});
        if (k) begin
            byte_io(o, r, k);
            byte_io(dv, r, k);
        end
        bus_stop;
    endtask

    // repeated start read, host nacks the single byte
    task rd(input [7:0] o, output [7:0] dv);
        reg [7:0] r;
        reg k;
        bus_start;
        byte_io({DEV, 1'b0}, r, k);
        byte_io(o, r, k);
        bus_start;
        byte_io({DEV, 1'b1}, r, k);
        byte_io(8'hff, dv, k);
        bus_stop;
    endtask

    // burst read from the first register, host acks the first byte
    task rd_pair(output [7:0] d0, output [7:0] d1);
        reg [7:0] r;
        reg k;
        integer i;
        bus_start;
        byte_io({DEV, 1'b0}, r, k);
        byte_io(8'hbd, r, k);
        bus_start;
        byte_io({DEV, 1'b1}, r, k);
        for (i = 7; i >= 0; i = i - 1) begin
            bit_io(1'b1, k);
            d0[i] = k;
        end
        bit_io(1'b0, k);
        byte_io(8'hff, d1, k);
        bus_stop;
    endtask

    task tally_and_finish;
        tick(2);
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watcher: drain every pending result against its oldest note
    initial forever begin
        @(res_ev);
        while (got_q.size() > 0) begin
            e = exp_q.pop_front();
            g = got_q.pop_front();
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                $display("Error at %0t: expected %h got %h", $time, e, g);
                n_fail = n_fail + 1;
            end
        end
    end

    // hang guard
    initial begin
        tick(60000);
        n_fail = n_fail + 1;
        tally_and_finish;
    end

    // main sequence
    initial begin
        tick(20);
        nrst_in <= 1'b1;
        tick(2);
        rd(8'hbd, d);
        chk(16'h0000, {8'h00, d});
        rd(8'hbe, d);
        chk(16'h0000, {8'h00, d});
        // every decode mode, random enables and thresholds
        for (m = 0; m < 4; m = m + 1) begin
            v = $random(seed);
            bd = {m[1:0], v[5:0]};
            be = v[15:8];
            vid_pins_in <= v[23:16];
            wr(DEV, 8'hbd, bd);
            wr(DEV, 8'hbe, be);
            tick(2);
            chk({8'h00, bd}, {8'h00, vsel, ctl});
            chk({9'h000, be[7:4], be[3:2] & {2{m == 0}}, be[0]},
                {9'h000, thr});
            rd(8'hbd, d);
            chk({8'h00, bd}, {8'h00, d});
            rd(8'hbe, d);
            chk({8'h00, be}, {8'h00, d});
            vid_pins_in <= v[31:24];
            tick(3);
        end
        // burst read: host acks the first byte, pointer steps on
        rd_pair(d, d2);
        chk({bd, be}, {d, d2});
        // unmapped offset is dropped, foreign address not acked
        wr(DEV, 8'hbf, 8'ha5);
        rd(8'hbf, d);
        chk(16'h0000, {8'h00, d});
        wr(7'h2d, 8'hbd, 8'h00);
        rd(8'hbd, d);
        chk({8'h00, bd}, {8'h00, d});
        // second reset in mid-run
        nrst_in <= 1'b0;
        tick(3);
        nrst_in <= 1'b1;
        tick(2);
        chk(16'h0000, {1'b0, vsel, ctl, thr});
        rd(8'hbe, d);
        chk(16'h0000, {8'h00, d});
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
